// ### rtl/aovd_decoder.v
// ascii output value decoder: field capture, checks, scaling, trim
`include "aovd_regs.vh"
module aovd_decoder (
  // clock and reset
  input  wire        CLOCK,
  input  wire        RSTN,
  // configuration, from logic on this clock
  input  wire [1:0]  FORMAT,
  input  wire [7:0]  RANGE,
  // value field, one character per strobe
  input  wire        CHAR_VALID,
  input  wire [7:0]  CHAR_DATA,
  input  wire        FIELD_END,
  // calibration commands
  input  wire        TRIM_STROBE,
  input  wire [7:0]  TRIM_COUNTS,
  input  wire        CAL_LOW,
  input  wire        CAL_HIGH,
  // results
  output reg         BUSY,
  output reg         OUT_VALID,
  output reg         OUT_ERROR,
  output reg  [11:0] OUT_CODE,
  output reg  [11:0] DAC_CODE
);

  localparam S_IDLE  = 3'b001;
  localparam S_CHECK = 3'b010;
  localparam S_DIV   = 3'b100;

  reg  [2:0]  state;
  reg  [2:0]  cnt;
  reg  [7:0]  fld [0:5];
  reg  [1:0]  fmt;
  reg  [7:0]  rng;

  reg  [26:0] num;
  reg  [16:0] den;
  reg  [16:0] rem;
  reg  [26:0] quo;
  reg  [4:0]  step;
  reg         first;

  reg  [11:0] trim;
  reg  [11:0] cal_low;
  reg  [11:0] cal_high;

  wire [5:0]  is_dig;
  wire [5:0]  is_hex;

  // inputs come from the command parser on CLOCK, so no synchroniser
  wire take_char = CHAR_VALID & ~FIELD_END & (state == S_IDLE);

  genvar i;
  generate
    for (i = 0; i < 6; i = i + 1) begin : g_chr
      always @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
          fld[i] <= 8'h00;
        end else if (take_char && cnt == i) begin
          fld[i] <= CHAR_DATA;
        end
      end

      assign is_dig[i] = (fld[i] >= `AOVD_CH_ZERO) &
                         (fld[i] <= `AOVD_CH_NINE);
      // minus sign and blanks fail here, so no value can go negative
      assign is_hex[i] = is_dig[i] |
        ((fld[i] >= `AOVD_CH_A_UP) & (fld[i] <= `AOVD_CH_F_UP)) |
        ((fld[i] >= `AOVD_CH_A_LO) & (fld[i] <= `AOVD_CH_F_LO));
    end
  endgenerate

  function [3:0] nib;
    input [7:0] c;
    input       dig;
    // letter nibble a..f is 1..6, plus 9 gives 10..15
    begin
      nib = dig ? c[3:0] : c[3:0] + 4'h9;
    end
  endfunction

  function [16:0] dec5;
    input [3:0] a;
    input [3:0] b;
    input [3:0] c;
    input [3:0] d;
    input [3:0] e;
    begin
      dec5 = {13'h0000, a} * `AOVD_K10000 +
             {13'h0000, b} * `AOVD_K1000 +
             {13'h0000, c} * `AOVD_K100 +
             {13'h0000, d} * `AOVD_K10 +
             {13'h0000, e};
    end
  endfunction

  // first character is the most significant nibble
  wire [11:0] hex_code = {nib(fld[0], is_dig[0]), nib(fld[1], is_dig[1]),
                          nib(fld[2], is_dig[2])};

  // engineering value in thousandths of a volt or milliamp
  wire [16:0] eng_val = dec5(fld[0][3:0], fld[1][3:0], fld[3][3:0],
                             fld[4][3:0], fld[5][3:0]);
  // percent in hundredths
  wire [16:0] pct_val = dec5(fld[0][3:0], fld[1][3:0], fld[2][3:0],
                             fld[4][3:0], fld[5][3:0]);

  // range code picks the offset and span of the engineering format
  wire        rng_ok = (rng == `AOVD_RNG_I20) | (rng == `AOVD_RNG_I4) |
                       (rng == `AOVD_RNG_V10);
  wire [16:0] r_min  = (rng == `AOVD_RNG_I4) ? `AOVD_MIN_I4 : 17'h0_0000;
  wire [16:0] r_span = (rng == `AOVD_RNG_I20) ? `AOVD_SPAN_I20 :
                       (rng == `AOVD_RNG_I4)  ? `AOVD_SPAN_I4 :
                                                `AOVD_SPAN_V10;
  wire [16:0] r_max  = r_min + r_span;

  // shape checks: length, digit positions, decimal point
  wire eng_shape = (cnt == `AOVD_ENG_LEN) & (&is_dig[1:0]) &
                   (fld[2] == `AOVD_CH_POINT) & (&is_dig[5:3]);
  wire pct_shape = (cnt == `AOVD_ENG_LEN) & (&is_dig[2:0]) &
                   (fld[3] == `AOVD_CH_POINT) & (&is_dig[5:4]);
  wire hex_shape = (cnt == `AOVD_HEX_LEN) & (&is_hex[2:0]);

  // value checks, only meaningful once the shape is right
  wire eng_low_ok  = (eng_val >= r_min);
  wire eng_high_ok = (eng_val <= r_max);
  wire pct_high_ok = (pct_val <= `AOVD_PCT_FULL);

  wire eng_ok = eng_shape & eng_low_ok & eng_high_ok;
  wire pct_ok = pct_shape & pct_high_ok;
  wire hex_ok = hex_shape;

  reg fld_ok;
  always @* begin
    case (fmt)
      `AOVD_FMT_ENG: fld_ok = rng_ok & eng_ok;
      `AOVD_FMT_PCT: fld_ok = rng_ok & pct_ok;
      `AOVD_FMT_HEX: fld_ok = rng_ok & hex_ok;
      default:       fld_ok = 1'b0;
    endcase
  end

  // offset from range minimum, times full code, plus half span to round
  wire [16:0] eng_ofs = eng_val - r_min;
  wire [26:0] eng_num = {10'h000, eng_ofs} * `AOVD_CODE_FULL +
                        {11'h000, r_span[16:1]};
  // first percent pass rounds to the nearest 0.2% step
  wire [26:0] pct_num = {10'h000, pct_val} +
                        {10'h000, `AOVD_PCT_STEP >> 1};

  // restoring divider, one quotient bit per cycle
  // dividend enters msb first; remainder stays below the divisor
  wire [17:0] trial = {rem, num[26]};
  wire        ge    = (trial >= {1'b0, den});
  wire [17:0] diff  = trial - {1'b0, den};
  wire [26:0] q_fin = {quo[25:0], ge};
  wire [26:0] pct2_num = {15'h0000, q_fin[11:0]} * `AOVD_CODE_FULL +
                         {10'h000, `AOVD_PCT_STEPS >> 1};

  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      state     <= S_IDLE;
      cnt       <= 3'h0;
      fmt       <= `AOVD_FMT_ENG;
      rng       <= `AOVD_RNG_I20;
      num       <= 27'h000_0000;
      den       <= 17'h0_0001;
      rem       <= 17'h0_0000;
      quo       <= 27'h000_0000;
      step      <= 5'h00;
      first     <= 1'b0;

      BUSY      <= 1'b0;
      OUT_VALID <= 1'b0;
      OUT_ERROR <= 1'b0;
      OUT_CODE  <= 12'h000;
    end else begin
      OUT_VALID <= 1'b0;
      OUT_ERROR <= 1'b0;

      case (state)
        S_IDLE: begin
          // end mark fixes format and range for this field
          if (FIELD_END) begin
            fmt   <= FORMAT;
            rng   <= RANGE;
            state <= S_CHECK;
            BUSY  <= 1'b1;
          end else if (take_char && cnt != 3'h7) begin
            // saturates so an overlong field stays a length error
            cnt <= cnt + 3'h1;
          end
        end

        S_CHECK: begin
          cnt  <= 3'h0;
          rem  <= 17'h0_0000;
          quo  <= 27'h000_0000;
          step <= `AOVD_DIV_STEPS;

          if (!fld_ok) begin
            OUT_ERROR <= 1'b1;
            BUSY      <= 1'b0;
            state     <= S_IDLE;
          end else if (fmt == `AOVD_FMT_HEX) begin
            // hex needs no arithmetic, answers at once
            OUT_CODE  <= hex_code;
            OUT_VALID <= 1'b1;
            BUSY      <= 1'b0;
            state     <= S_IDLE;
          end else if (fmt == `AOVD_FMT_PCT) begin
            num   <= pct_num;
            den   <= `AOVD_PCT_STEP;
            first <= 1'b1;
            state <= S_DIV;
          end else begin
            num   <= eng_num;
            den   <= r_span;
            first <= 1'b0;
            state <= S_DIV;
          end
        end

        S_DIV: begin
          rem  <= ge ? diff[16:0] : trial[16:0];
          quo  <= q_fin;
          num  <= {num[25:0], 1'b0};
          step <= step - 5'h01;

          if (step == 5'h00) begin
            rem <= 17'h0_0000;
            quo <= 27'h000_0000;
            if (first) begin
              // steps of 0.2% scaled over the whole span
              num   <= pct2_num;
              den   <= `AOVD_PCT_STEPS;
              first <= 1'b0;
              step  <= `AOVD_DIV_STEPS;
            end else begin
              // rounding numerator stays below span times 4096
              OUT_CODE  <= q_fin[11:0];
              OUT_VALID <= 1'b1;
              BUSY      <= 1'b0;
              state     <= S_IDLE;
            end
          end
        end

        default: begin
          state <= S_IDLE;
          BUSY  <= 1'b0;
        end
      endcase
    end
  end

  // counts arrive signed; widened to the trim width
  wire [11:0] trim_step = {{4{TRIM_COUNTS[7]}}, TRIM_COUNTS};

  // calibration: anchors start at factory values, trim is live
  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      trim     <= 12'h000;
      cal_low  <= `AOVD_CAL_LOW_RST;
      cal_high <= `AOVD_CAL_HIGH_RST;
    end else if (CAL_LOW) begin
      cal_low <= cal_low + trim;
      trim    <= 12'h000;
    end else if (CAL_HIGH) begin
      cal_high <= cal_high + trim;
      trim     <= 12'h000;
    end else if (TRIM_STROBE) begin
      // wraps at 12 bits; trims are small in practice
      trim <= trim + trim_step;
    end
  end

  // offset interpolated between low anchor at code 0 and high at full
  wire [12:0] cal_diff = {cal_high[11], cal_high} - {cal_low[11], cal_low};
  wire [25:0] cal_prod = $signed(cal_diff) * $signed({1'b0, OUT_CODE});
  wire [13:0] cal_off  = {{2{cal_low[11]}}, cal_low} + cal_prod[25:12];

  // all terms widened so the clamp sees both sign and overflow
  wire [15:0] code_ext = {4'h0, OUT_CODE};
  wire [15:0] off_ext  = {{2{cal_off[13]}}, cal_off};
  wire [15:0] trim_ext = {{4{trim[11]}}, trim};
  wire [15:0] dac_sum  = code_ext + off_ext + trim_ext;
  wire        dac_neg  = dac_sum[15];
  wire        dac_over = (dac_sum[14:12] != 3'h0);

  // clamp keeps the converter code inside its 12-bit scale
  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      DAC_CODE <= 12'h000;
    end else if (dac_neg) begin
      DAC_CODE <= 12'h000;
    end else if (dac_over) begin
      DAC_CODE <= 12'hFFF;
    end else begin
      DAC_CODE <= dac_sum[11:0];
    end
  end

endmodule // aovd_decoder

// ### rtl/aovd_regs.vh
// constants for the ascii output value decoder
// Function
// - format 00 selects engineering units
// - engineering field: dd.ddd, six characters
// - volts on voltage range, milliamps otherwise
// - format 01 selects percent of span
// - percent field: ddd.dd, 000.00 to 100.00
// - percent measured from range minimum
// - percent resolved in 0.2% steps
// - format 10: three hex characters, 12 bits
// - FFF is range maximum, 000 minimum
// - range codes 30, 31, 32 decoded
// - engineering values bounded per range
// - no negative values accepted
// - factory calibration used until replaced
`ifndef AOVD_REGS_VH
`define AOVD_REGS_VH
`define AOVD_FMT_ENG    2'h0
`define AOVD_FMT_PCT    2'h1
`define AOVD_FMT_HEX    2'h2
`define AOVD_RNG_I20    8'h30
`define AOVD_RNG_I4     8'h31
`define AOVD_RNG_V10    8'h32
`define AOVD_ENG_LEN    3'h6
`define AOVD_HEX_LEN    3'h3
`define AOVD_MIN_I4     17'h0_0FA0
`define AOVD_SPAN_I20   17'h0_4E20
`define AOVD_SPAN_I4    17'h0_3E80
`define AOVD_SPAN_V10   17'h0_2710
`define AOVD_PCT_FULL   17'h0_2710
`define AOVD_PCT_STEP   17'h0_0014
`define AOVD_PCT_STEPS  17'h0_01F4
`define AOVD_CODE_FULL  27'h000_0FFF
`define AOVD_DIV_STEPS  5'h1A
`define AOVD_CAL_LOW_RST  12'h000
`define AOVD_CAL_HIGH_RST 12'h000
`define AOVD_CH_ZERO    8'h30
`define AOVD_CH_NINE    8'h39
`define AOVD_CH_POINT   8'h2E
`define AOVD_CH_A_UP    8'h41
`define AOVD_CH_F_UP    8'h46
`define AOVD_CH_A_LO    8'h61
`define AOVD_CH_F_LO    8'h66
`define AOVD_K10000     17'h0_2710
`define AOVD_K1000      17'h0_03E8
`define AOVD_K100       17'h0_0064
`define AOVD_K10        17'h0_000A
`endif

// ### tb/aovd_host.sv
// host model: sends value fields and calibration commands
module aovd_host (
  // clock
  input  wire logic CLOCK,
  // value field
  output logic       CHAR_VALID,
  output logic [7:0] CHAR_DATA,
  output logic       FIELD_END,
  // calibration
  output logic       TRIM_STROBE,
  output logic [7:0] TRIM_COUNTS,
  output logic       CAL_LOW,
  output logic       CAL_HIGH
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {CHAR_VALID, FIELD_END, TRIM_STROBE, CAL_LOW, CAL_HIGH} = 5'h00;
    CHAR_DATA = 8'h00;
    TRIM_COUNTS = 8'h00;
  end
  // most significant character first, then the end mark
  task automatic send(input string txt);
    for (int i = 0; i < txt.len(); i++) begin
      @(posedge CLOCK);
      CHAR_VALID <= 1'b1;
      CHAR_DATA <= txt[i];
    end
    @(posedge CLOCK);
    CHAR_VALID <= 1'b0;
    // released data must not look like a held character
    CHAR_DATA <= ~CHAR_DATA;
    FIELD_END <= 1'b1;
    @(posedge CLOCK);
    FIELD_END <= 1'b0;
  endtask
  // kind bits: high point, low point, trim
  task automatic cal(input logic [2:0] kind, input logic [7:0] n);
    @(posedge CLOCK);
    {CAL_HIGH, CAL_LOW, TRIM_STROBE} <= kind;
    TRIM_COUNTS <= n;
    @(posedge CLOCK);
    {CAL_HIGH, CAL_LOW, TRIM_STROBE} <= 3'h0;
    TRIM_COUNTS <= ~n;
  endtask
endmodule // aovd_host

// ### tb/aovd_monitor.sv
// assertion checker for the ascii output value decoder
module aovd_monitor (
  // clock and reset
  input wire logic        CLOCK,
  input wire logic        RSTN,
  // field side
  input wire logic [1:0]  FORMAT,
  input wire logic [7:0]  RANGE,
  input wire logic        FIELD_END,
  // results
  input wire logic        BUSY,
  input wire logic        OUT_VALID,
  input wire logic        OUT_ERROR,
  input wire logic [11:0] OUT_CODE
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking mon_cb @(posedge CLOCK);
  endclocking
  default disable iff (!RSTN);
  wire take = FIELD_END && !BUSY;
  wire done = OUT_VALID || OUT_ERROR;
  chk_busy_rise: assert property (take |=> BUSY)
    else $error("busy not raised by field end");
  chk_hex_answer: assert property (take && FORMAT == 2'h2 |->
    ##2 done) else $error("hex result late");
  chk_fmt_reject: assert property (take && FORMAT == 2'h3 |->
    ##2 OUT_ERROR) else $error("format 11 not refused");
  chk_range_reject: assert property (take && (RANGE < 8'h30 ||
    RANGE > 8'h32) |-> ##2 OUT_ERROR) else $error("bad range not refused");
  chk_eng_answer: assert property (take && FORMAT == 2'h0 |->
    (##2 OUT_ERROR) or (##29 done)) else $error("eng result timing");
  chk_pct_answer: assert property (take && FORMAT == 2'h1 |->
    (##2 OUT_ERROR) or (##56 done)) else $error("pct result timing");
  chk_pulse_excl: assert property (!(OUT_VALID && OUT_ERROR))
    else $error("valid and error together");
  chk_code_hold: assert property ($changed(OUT_CODE) |-> OUT_VALID)
    else $error("code moved without valid");
  chk_busy_drop: assert property (done |-> !BUSY && $past(BUSY))
    else $error("busy not dropped with result");
  cover property (OUT_VALID && $past(FORMAT) == 2'h2);
  cover property (OUT_ERROR);
  cover property (take && FORMAT == 2'h1);
endmodule // aovd_monitor

bind aovd_decoder aovd_monitor u_mon (.CLOCK(CLOCK), .RSTN(RSTN),
  .FORMAT(FORMAT), .RANGE(RANGE), .FIELD_END(FIELD_END), .BUSY(BUSY),
  .OUT_VALID(OUT_VALID), .OUT_ERROR(OUT_ERROR), .OUT_CODE(OUT_CODE));

// ### tb/test_aovd_decoder.sv
// self-checking testbench for the ascii output value decoder
module test_aovd_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [1:0]  fmt;
    logic [7:0]  rng;
    string       txt;
    logic        ok;
    logic [11:0] code;
  } aovd_row_t;
  logic        CLOCK, RSTN, CHAR_VALID, FIELD_END, TRIM_STROBE;
  logic        CAL_LOW, CAL_HIGH, BUSY, OUT_VALID, OUT_ERROR;
  logic [1:0]  FORMAT;
  logic [7:0]  RANGE, CHAR_DATA, TRIM_COUNTS;
  logic [11:0] OUT_CODE, DAC_CODE;
  int          fails = 0;
  int          samples_checked = 0;
  aovd_row_t rows [16] = '{
    '{2'h0, 8'h30, "05.678", 1'b1, 12'h48b},
    '{2'h0, 8'h32, "10.000", 1'b1, 12'hfff},
    '{2'h0, 8'h31, "04.000", 1'b1, 12'h000},
    '{2'h0, 8'h31, "03.999", 1'b0, 12'h000},
    '{2'h0, 8'h30, "-1.000", 1'b0, 12'h000},
    '{2'h0, 8'h30, "05678", 1'b0, 12'h000},
    '{2'h1, 8'h30, "050.00", 1'b1, 12'h800},
    '{2'h1, 8'h31, "037.50", 1'b1, 12'h604},
    '{2'h1, 8'h30, "000.09", 1'b1, 12'h000},
    '{2'h1, 8'h30, "000.10", 1'b1, 12'h008},
    '{2'h1, 8'h32, "100.01", 1'b0, 12'h000},
    '{2'h2, 8'h30, "7FF", 1'b1, 12'h7ff},
    '{2'h2, 8'h31, "fff", 1'b1, 12'hfff},
    '{2'h2, 8'h32, "000", 1'b1, 12'h000},
    '{2'h3, 8'h30, "7FF", 1'b0, 12'h000},
    '{2'h2, 8'h33, "000", 1'b0, 12'h000}};
  aovd_decoder DUT (.CLOCK(CLOCK), .RSTN(RSTN), .FORMAT(FORMAT),
    .RANGE(RANGE), .CHAR_VALID(CHAR_VALID), .CHAR_DATA(CHAR_DATA),
    .FIELD_END(FIELD_END), .TRIM_STROBE(TRIM_STROBE),
    .TRIM_COUNTS(TRIM_COUNTS), .CAL_LOW(CAL_LOW), .CAL_HIGH(CAL_HIGH),
    .BUSY(BUSY), .OUT_VALID(OUT_VALID), .OUT_ERROR(OUT_ERROR),
    .OUT_CODE(OUT_CODE), .DAC_CODE(DAC_CODE));
  aovd_host host (.CLOCK(CLOCK), .CHAR_VALID(CHAR_VALID),
    .CHAR_DATA(CHAR_DATA), .FIELD_END(FIELD_END),
    .TRIM_STROBE(TRIM_STROBE), .TRIM_COUNTS(TRIM_COUNTS),
    .CAL_LOW(CAL_LOW), .CAL_HIGH(CAL_HIGH));
  initial begin
    CLOCK = 1'b0;
    forever #5 CLOCK = ~CLOCK;
  end
  task complete_run;
    if (fails == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task check(input string what, input logic [11:0] exp,
             input logic [11:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // values read at the edge are those of the cycle just ended
  task wait_result;
    for (int n = 0; n < 100; n++) begin
      @(posedge CLOCK);
      if (OUT_VALID === 1'b1 || OUT_ERROR === 1'b1)
        return;
    end
    fails++;
    $display("[FAIL] result expected 1 seen 0");
    complete_run();
  endtask
  task cal_check(input logic [2:0] kind, input logic [11:0] exp);
    host.cal(kind, 8'h05);
    repeat (3) @(posedge CLOCK);
    check("dac", exp, DAC_CODE);
  endtask
  initial begin
    RSTN = 1'b0;
    FORMAT = 2'h0;
    RANGE = 8'h30;
    repeat (5) @(posedge CLOCK);
    RSTN <= 1'b1;
    foreach (rows[i]) begin
      FORMAT <= rows[i].fmt;
      RANGE <= rows[i].rng;
      host.send(rows[i].txt);
      wait_result();
      check("accept", {11'h000, rows[i].ok}, {11'h000, OUT_VALID});
      if (rows[i].ok)
        check("code", rows[i].code, OUT_CODE);
    end
    FORMAT <= 2'h2;
    RANGE <= 8'h30;
    host.send("400");
    wait_result();
    repeat (2) @(posedge CLOCK);
    check("dac", 12'h400, DAC_CODE);
    cal_check(3'h1, 12'h405);
    cal_check(3'h2, 12'h403);
    cal_check(3'h1, 12'h408);
    cal_check(3'h4, 12'h405);
    RSTN <= 1'b0;
    repeat (2) @(posedge CLOCK);
    check("code", 12'h000, OUT_CODE);
    check("dac", 12'h000, DAC_CODE);
    // factory anchors again after reset: no offset on the code
    RSTN <= 1'b1;
    host.send("123");
    wait_result();
    repeat (2) @(posedge CLOCK);
    check("dac", 12'h123, DAC_CODE);
    complete_run();
  end
endmodule // test_aovd_decoder
